/* src/pdm_ctrl.sv */
// Operation
// R1: halt register resets to 3FFF on reset and hardware standby; kept in software standby.
// R2: halt bit zero runs the module, one stops it.
// R3: non-zero divider enters medium speed at end of current bus cycle.
// R4: bus masters use divided clock in medium speed; other modules stay on full clock.
// R5: at divide-by-four, memory access lasts four clocks, register access eight.
// R6: divider all zero returns to full speed at end of bus cycle.
// R7: sleep with select zero halts CPU only; modules keep running.
// R8: wake from sleep or software standby restores previous divider setting.
// R9: pin reset or watchdog reset cancels medium speed.
// R10: hardware standby pin low enters hardware standby from any mode.
// R11: sleep ends on interrupt unless disabled or non-NMI interrupts masked.
// R12: halt bit set stops module at end of bus cycle; CPU continues.
// R13: halt bit cleared restarts module at end of bus cycle.
// R14: stopped modules keep state except serial channels and A/D converter.
// R15: after reset all gated modules stop except DMA and transfer controller.
// R16: register access to a stopped module is blocked.
// R17: software must not sleep with halt register FFFF or EFFF.
// R18: bits 15..9 and 7..5 map to the listed modules.
// R19: bits 8 and 4..0 are plain storage without effect.
// R20: DMA and transfer controller halt bits refuse setting while active.
// R21: software disables module interrupts before halting it.
// R22: only the CPU writes the halt register.
// R23: divider 000 full speed; 001..101 divide by 2, 4, 8, 16, 32.
// R24: standby select zero makes sleep, one makes software standby.
// R25: clock switch and gating wait for the bus controller's end-of-cycle.
`timescale 1ns/1ns
`default_nettype none
module pdm_ctrl
   import pdm_pkg::*;
(
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   // register port
   input  wire pdm_reg_req_t regReq,
   output logic [15:0]       regRdData,
   // system events
   input  wire logic         hwStandbyPinN,
   input  wire logic         wdtReset,
   input  wire logic         busCycleEnd,
   input  wire logic         sleepExec,
   input  wire pdm_wake_t    wake,
   input  wire logic         dmaActive,
   input  wire logic         xferActive,
   // module access
   input  wire logic [15:0]  modAccessReq,
   output logic [15:0]       modAccessGrant,
   // clock control
   output logic              masterClkEn,
   output logic              cpuHalt,
   output logic [15:0]       moduleRun,
   output logic [15:0]       moduleStateClear,
   output logic [LEN_W-1:0]  memAccessLen,
   output logic [LEN_W-1:0]  ioAccessLen,
   output logic              wakeException,
   output pdm_mode_t         powerMode
);

   pdm_state_t       state;
   pdm_state_t       next_state;
   logic [CNT_W-1:0] divMask;
   logic             wakeSleep;
   logic             masterRuns;
   logic             hwEvent;

   // ----------------------------------------------------------------
   // combinational decode
   // ----------------------------------------------------------------
   // at divide by 32 the shift wraps to zero, so the mask wraps to all ones
   assign divMask     = CNT_W'((CNT_ONE << state.divAct) - CNT_ONE);  // R23
   assign masterRuns  = (state.mode == PDM_RUN) || (state.mode == PDM_SLEEP);
   assign masterClkEn = masterRuns && (state.divCnt == divMask);  // R4
   assign wakeSleep   = wake.nmiPending ||
                        (wake.irqPending && !wake.irqDisabled && !wake.nonNmiMasked);  // R11
   // acts only on the synchronised pin level, never on the raw pin
   assign hwEvent     = !state.hwStbyLvl;
   assign wakeException = (state.mode == PDM_SLEEP && wakeSleep && !hwEvent && !wdtReset) ||
                          (state.mode == PDM_SWSTBY && wake.extIrq && !hwEvent && !wdtReset);
   assign cpuHalt     = (state.mode != PDM_RUN);  // R7
   assign powerMode   = state.mode;
   assign regRdData   = state.rdData;
   assign memAccessLen = LEN_W'(MEM_MASTER_STATES << state.divAct);  // R5
   assign ioAccessLen  = LEN_W'(IO_MASTER_STATES << state.divAct);  // R5

   // ----------------------------------------------------------------
   // per-module gating
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 16; gi++) begin : g_mod
         if (HALT_USED[gi]) begin : g_used
            // zero runs, one stops; standby stops everything
            assign moduleRun[gi]        = masterRuns && !state.appliedHalt[gi];  // R2 R7 R18
            assign moduleStateClear[gi] = HALT_VOLATILE[gi] && state.appliedHalt[gi];  // R14
            assign modAccessGrant[gi]   = modAccessReq[gi] && masterRuns && !state.appliedHalt[gi];  // R16
         end else begin : g_spare
            assign moduleRun[gi]        = 1'b0;  // R19
            assign moduleStateClear[gi] = 1'b0;
            assign modAccessGrant[gi]   = 1'b0;
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;

      // pin synchroniser: only the second and third stage are compared
      next_state.pinSync = {state.pinSync[1:0], hwStandbyPinN};
      if (state.pinSync[1] == state.pinSync[2]) begin
         next_state.hwStbyLvl = state.pinSync[2];
      end

      // read data stands in the cycle after the strobe
      next_state.rdData = ZERO_WORD;
      if (regReq.rd) begin
         if (regReq.addr == OFS_HALT) begin
            next_state.rdData = state.halt;
         end else if (regReq.addr == OFS_CLK_CTRL) begin
            next_state.rdData = {13'h0000, state.divReq};
         end else if (regReq.addr == OFS_HW_STANDBY_PIN_CTRL) begin
            next_state.rdData = {8'h00, state.stbySel, 7'h00};
         end else if (regReq.addr == OFS_STATUS) begin
            next_state.rdData = {11'h000, state.divAct, state.mode};
         end else begin
            next_state.rdData = ZERO_WORD;
         end
      end

      // register writes
      if (regReq.wr) begin
         if (regReq.addr == OFS_HALT) begin
            next_state.halt = regReq.wrData;  // R22
            // a busy dma or transfer unit keeps its stop bit clear
            if (dmaActive && !state.halt[BIT_DMA]) begin
               next_state.halt[BIT_DMA] = 1'b0;  // R20
            end
            if (xferActive && !state.halt[BIT_XFER]) begin
               next_state.halt[BIT_XFER] = 1'b0;  // R20
            end
         end else if (regReq.addr == OFS_CLK_CTRL) begin
            if (regReq.wrData[DIV_W-1:0] <= DIV_MAX) begin
               next_state.divReq = regReq.wrData[DIV_W-1:0];  // R23
            end
         end else if (regReq.addr == OFS_HW_STANDBY_PIN_CTRL) begin
            next_state.stbySel = regReq.wrData[HW_STANDBY_PIN_SEL_BIT];  // R24
         end
      end

      // divider and gating follow the end of the bus cycle
      if (busCycleEnd) begin
         next_state.divAct      = state.divReq;  // R3 R6 R25
         next_state.appliedHalt = state.halt;  // R12 R13 R25
      end

      // divided bus-master clock
      if (next_state.divAct != state.divAct || state.divCnt == divMask) begin
         next_state.divCnt = CNT_ZERO;  // R4
      end else begin
         next_state.divCnt = CNT_W'(state.divCnt + CNT_ONE);
      end

      // power mode sequencing
      case (state.mode)
         PDM_RUN: begin
            if (sleepExec) begin
               next_state.mode = state.stbySel ? PDM_SWSTBY : PDM_SLEEP;  // R7 R24
            end
         end
         PDM_SLEEP: begin
            if (wakeSleep) begin
               next_state.mode = PDM_RUN;  // R8 R11
            end
         end
         PDM_SWSTBY: begin
            if (wake.extIrq) begin
               next_state.mode = PDM_RUN;  // R8
            end
         end
         PDM_HWSTBY: begin
            if (state.hwStbyLvl) begin
               next_state.mode = PDM_RUN;
            end
         end
         default: begin
            next_state.mode = PDM_RUN;
         end
      endcase

      // watchdog reset and hardware standby reload the controls
      if (wdtReset || hwEvent) begin
         next_state.halt        = HALT_RESET;  // R1 R15
         next_state.appliedHalt = HALT_RESET;  // R15
         next_state.divReq      = DIV_FULL;  // R9
         next_state.divAct      = DIV_FULL;  // R9
         next_state.stbySel     = 1'b0;
         next_state.divCnt      = CNT_ZERO;
         next_state.mode        = hwEvent ? PDM_HWSTBY : PDM_RUN;  // R10
      end
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= PDM_STATE_RESET;  // R1 R9 R15
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_n);

   property p_halt_reload;
      wdtReset |=> state.halt == 16'h3FFF && moduleRun == 16'hC000;
   endproperty
   a_halt_reload: assert property (p_halt_reload) else $error("halt register not reloaded");  // R1

   property p_halt_kept_swstby;
      (state.mode == PDM_SWSTBY && !regReq.wr && !wdtReset && !hwEvent) |=> $stable(state.halt);
   endproperty
   a_halt_kept_swstby: assert property (p_halt_kept_swstby) else $error("halt lost in standby");  // R1

   property p_div_switch;
      (busCycleEnd && !wdtReset && !hwEvent && state.divReq != state.divAct)
         |=> state.divAct == $past(state.divReq);
   endproperty
   a_div_switch: assert property (p_div_switch) else $error("divider not applied at cycle end");  // R3

   property p_div_hold;
      (!busCycleEnd && !wdtReset && !hwEvent) |=> $stable(state.divAct) && $stable(state.appliedHalt);
   endproperty
   a_div_hold: assert property (p_div_hold) else $error("switch outside bus cycle end");  // R25

   property p_div4_lengths;
      (state.divAct == 3'h2) |-> memAccessLen == 7'h04 && ioAccessLen == 7'h08;
   endproperty
   a_div4_lengths: assert property (p_div4_lengths) else $error("access length wrong at div 4");  // R5

   property p_div4_spacing;
      (masterClkEn && state.divAct == 3'h2 && state.divReq == state.divAct && !wdtReset && !hwEvent)
         |=> !masterClkEn ##1 (state.divAct != 3'h2 || !masterClkEn);
   endproperty
   a_div4_spacing: assert property (p_div4_spacing) else $error("divided clock too fast");  // R4

   property p_wdt_cancel;
      wdtReset |=> state.divAct == 3'h0 && state.divReq == 3'h0 && masterClkEn;
   endproperty
   a_wdt_cancel: assert property (p_wdt_cancel) else $error("medium speed not cancelled");  // R9

   property p_hw_standby;
      hwEvent |=> state.mode == PDM_HWSTBY && moduleRun == 16'h0000;
   endproperty
   a_hw_standby: assert property (p_hw_standby) else $error("hardware standby not entered");  // R10

   property p_sleep_blocked;
      (state.mode == PDM_SLEEP && !wake.nmiPending && (wake.irqDisabled || wake.nonNmiMasked)
         && !wdtReset && !hwEvent) |=> state.mode == PDM_SLEEP;
   endproperty
   a_sleep_blocked: assert property (p_sleep_blocked) else $error("sleep left while masked");  // R11

   property p_sleep_modules;
      (state.mode == PDM_SLEEP) |-> cpuHalt && moduleRun == (16'hFEE0 & ~state.appliedHalt);
   endproperty
   a_sleep_modules: assert property (p_sleep_modules) else $error("modules stopped in sleep");  // R7

   property p_block_access;
      (|(modAccessReq & state.appliedHalt)) |-> (modAccessGrant & state.appliedHalt) == 16'h0000;
   endproperty
   a_block_access: assert property (p_block_access) else $error("stopped module accessed");  // R16

   property p_dma_refuse;
      (regReq.wr && regReq.addr == 4'h0 && dmaActive && !state.halt[15] && !wdtReset && !hwEvent)
         |=> !state.halt[15];
   endproperty
   a_dma_refuse: assert property (p_dma_refuse) else $error("dma halt set while active");  // R20

   property p_wake_restore;
      (state.mode == PDM_SLEEP && wakeSleep && !wdtReset && !hwEvent)
         |=> state.mode == PDM_RUN && state.divReq == $past(state.divReq);
   endproperty
   a_wake_restore: assert property (p_wake_restore) else $error("wake lost divider");  // R8

   property p_halt_apply;
      (busCycleEnd && !wdtReset && !hwEvent) |=> state.appliedHalt == $past(state.halt);
   endproperty
   a_halt_apply: assert property (p_halt_apply) else $error("halt not applied at cycle end");  // R12

   property p_halt_release;
      (busCycleEnd && masterRuns && !sleepExec && !wdtReset && !hwEvent)
         |=> (HALT_USED & ~$past(state.halt) & ~moduleRun) == HALT_ALL_OFF;
   endproperty
   a_halt_release: assert property (p_halt_release) else $error("cleared module not restarted");  // R13

   property p_spare_idle;
      (moduleRun & ~HALT_USED) == HALT_ALL_OFF;
   endproperty
   a_spare_idle: assert property (p_spare_idle) else $error("spare bit drives a module");  // R19

   property p_state_kept;
      (moduleStateClear & ~HALT_VOLATILE) == HALT_ALL_OFF;
   endproperty
   a_state_kept: assert property (p_state_kept) else $error("retained module state cleared");  // R14

   property p_sleep_enter;
      (state.mode == PDM_RUN && sleepExec && !state.stbySel && !wdtReset && !hwEvent)
         |=> state.mode == PDM_SLEEP && cpuHalt;
   endproperty
   a_sleep_enter: assert property (p_sleep_enter) else $error("sleep not entered");  // R7

   property p_swstby_enter;
      (state.mode == PDM_RUN && sleepExec && state.stbySel && !wdtReset && !hwEvent)
         |=> state.mode == PDM_SWSTBY && moduleRun == HALT_ALL_OFF;
   endproperty
   a_swstby_enter: assert property (p_swstby_enter) else $error("software standby not entered");  // R24

   property p_swstby_wake;
      (state.mode == PDM_SWSTBY && wake.extIrq && !regReq.wr && !wdtReset && !hwEvent)
         |-> wakeException ##1 state.mode == PDM_RUN && state.divReq == $past(state.divReq);
   endproperty
   a_swstby_wake: assert property (p_swstby_wake) else $error("standby wake lost divider");  // R8

   property p_xfer_refuse;
      (regReq.wr && regReq.addr == OFS_HALT && xferActive && !state.halt[BIT_XFER] && !wdtReset && !hwEvent)
         |=> !state.halt[BIT_XFER];
   endproperty
   a_xfer_refuse: assert property (p_xfer_refuse) else $error("transfer halt set while active");  // R20

   property p_div_range;
      state.divReq <= DIV_MAX;
   endproperty
   a_div_range: assert property (p_div_range) else $error("divider out of range");  // R23

   property p_div_full;
      (state.divAct == DIV_FULL && masterRuns) |-> masterClkEn;
   endproperty
   a_div_full: assert property (p_div_full) else $error("full speed clock gapped");  // R6

   property p_divided_gap;
      (masterClkEn && state.divAct != DIV_FULL && state.divReq == state.divAct && !wdtReset && !hwEvent)
         |=> !masterClkEn;
   endproperty
   a_divided_gap: assert property (p_divided_gap) else $error("divided clock without gap");  // R4

   property p_hw_reload;
      hwEvent |=> state.halt == HALT_RESET && state.divReq == DIV_FULL && !state.stbySel;
   endproperty
   a_hw_reload: assert property (p_hw_reload) else $error("standby did not reload controls");  // R1

   property p_sleep_exit;
      (state.mode == PDM_SLEEP && wakeSleep && !wdtReset && !hwEvent) |-> wakeException;
   endproperty
   a_sleep_exit: assert property (p_sleep_exit) else $error("sleep wake not taken");  // R11

   property p_grant_run;
      (modAccessGrant & ~moduleRun) == HALT_ALL_OFF;
   endproperty
   a_grant_run: assert property (p_grant_run) else $error("access to halted module");  // R16

   c_sleep_wake: cover property (state.mode == PDM_SLEEP ##[1:50] state.mode == PDM_RUN);
   c_swstby_wake: cover property (state.mode == PDM_SWSTBY ##[1:50] wakeException);
   c_div_change: cover property (busCycleEnd && state.divReq == 3'h5 && state.divAct == 3'h0);
   c_hw_standby: cover property (state.mode == PDM_HWSTBY ##[1:20] state.mode == PDM_RUN);
   c_dma_refused: cover property (regReq.wr && regReq.addr == OFS_HALT && dmaActive && regReq.wrData[BIT_DMA]);

endmodule : pdm_ctrl
`default_nettype wire

/* src/pdm_pkg.sv */
package pdm_pkg;

   // ----------------------------------------------------------------
   // register bus and map
   // ----------------------------------------------------------------
   localparam int          ADDR_W         = 4;
   localparam int          DATA_W         = 16;
   localparam logic [3:0]  OFS_HALT       = 4'h0;
   localparam logic [3:0]  OFS_CLK_CTRL   = 4'h1;
   localparam logic [3:0]  OFS_HW_STANDBY_PIN_CTRL  = 4'h2;
   localparam logic [3:0]  OFS_STATUS     = 4'h3;
   localparam logic [15:0] ZERO_WORD      = 16'h0000;

   // ----------------------------------------------------------------
   // module halt register fields
   // ----------------------------------------------------------------
   localparam logic [15:0] HALT_RESET     = 16'h3FFF;
   localparam logic [15:0] HALT_USED      = 16'hFEE0;
   localparam logic [15:0] HALT_VOLATILE  = 16'h02E0;
   localparam logic [15:0] HALT_ALL_OFF   = 16'h0000;
   localparam int          BIT_DMA        = 15;
   localparam int          BIT_XFER       = 14;

   // ----------------------------------------------------------------
   // clock divider and standby select
   // ----------------------------------------------------------------
   localparam int          DIV_W          = 3;
   localparam int          CNT_W          = 5;
   localparam int          LEN_W          = 7;
   localparam logic [2:0]  DIV_FULL       = 3'h0;
   localparam logic [2:0]  DIV_MAX        = 3'h5;
   localparam int          HW_STANDBY_PIN_SEL_BIT   = 7;
   localparam logic [LEN_W-1:0] MEM_MASTER_STATES = 7'h01;
   localparam logic [LEN_W-1:0] IO_MASTER_STATES  = 7'h02;
   localparam logic [CNT_W-1:0] CNT_ZERO  = 5'h00;
   localparam logic [CNT_W-1:0] CNT_ONE   = 5'h01;

   typedef enum logic [1:0] {
      PDM_RUN    = 2'b00,
      PDM_SLEEP  = 2'b01,
      PDM_SWSTBY = 2'b10,
      PDM_HWSTBY = 2'b11
   } pdm_mode_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wrData;
      logic              wr;
      logic              rd;
   } pdm_reg_req_t;

   typedef struct packed {
      logic irqPending;
      logic irqDisabled;
      logic nonNmiMasked;
      logic nmiPending;
      logic extIrq;
   } pdm_wake_t;

   typedef struct packed {
      logic [15:0]      halt;
      logic [15:0]      appliedHalt;
      logic [DIV_W-1:0] divReq;
      logic [DIV_W-1:0] divAct;
      logic             stbySel;
      pdm_mode_t        mode;
      logic [CNT_W-1:0] divCnt;
      logic [15:0]      rdData;
      logic [2:0]       pinSync;
      logic             hwStbyLvl;
   } pdm_state_t;

   localparam pdm_state_t PDM_STATE_RESET = '{
      halt: HALT_RESET, appliedHalt: HALT_RESET, divReq: DIV_FULL, divAct: DIV_FULL,
      stbySel: 1'b0, mode: PDM_RUN, divCnt: CNT_ZERO, rdData: ZERO_WORD,
      pinSync: 3'h7, hwStbyLvl: 1'b1};

endpackage : pdm_pkg

/* tb/pdm_bus_model.sv */
`timescale 1ns/1ns
`default_nettype none
module pdm_bus_model (
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst_n,
   // bus cycle length in clocks, zero stalls the bus
   input  wire logic [3:0] cycLen,
   // to the controller
   output logic            busCycleEnd
);
   logic [3:0] cnt;
   logic       last;

   assign last = (cnt + 4'h1) >= cycLen;

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt         <= 4'h0;
         busCycleEnd <= 1'b0;
      end else begin
         cnt         <= last ? 4'h0 : cnt + 4'h1;
         busCycleEnd <= (cycLen != 4'h0) && last;
      end
   end
endmodule : pdm_bus_model
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ns
`default_nettype none
module tb;
   import pdm_pkg::*;
   logic         core_clk;
   logic         rst_n;
   logic         hwStandbyPinN;
   logic         wdtReset;
   logic         sleepExec;
   logic         dmaActive;
   logic         xferActive;
   logic         busCycleEnd;
   logic [3:0]   cycLen;
   logic [15:0]  modAccessReq;
   logic [15:0]  modAccessGrant;
   logic [15:0]  regRdData;
   logic [15:0]  moduleRun;
   logic [15:0]  moduleStateClear;
   logic [6:0]   memAccessLen;
   logic [6:0]   ioAccessLen;
   logic         masterClkEn;
   logic         cpuHalt;
   logic         wakeException;
   pdm_mode_t    powerMode;
   pdm_reg_req_t regReq;
   pdm_wake_t    wake;
   int           errors;
   int           samplesChecked;
   logic [15:0]  d;

   pdm_ctrl pdm_ctrl_i (.core_clk(core_clk), .rst_n(rst_n), .regReq(regReq), .regRdData(regRdData),
      .hwStandbyPinN(hwStandbyPinN), .wdtReset(wdtReset), .busCycleEnd(busCycleEnd), .sleepExec(sleepExec),
      .wake(wake), .dmaActive(dmaActive), .xferActive(xferActive), .modAccessReq(modAccessReq),
      .modAccessGrant(modAccessGrant), .masterClkEn(masterClkEn), .cpuHalt(cpuHalt), .moduleRun(moduleRun),
      .moduleStateClear(moduleStateClear), .memAccessLen(memAccessLen), .ioAccessLen(ioAccessLen),
      .wakeException(wakeException), .powerMode(powerMode));
   pdm_bus_model pdm_bus_model_i (.core_clk(core_clk), .rst_n(rst_n), .cycLen(cycLen), .busCycleEnd(busCycleEnd));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic summarize;
      if (errors == 0 && samplesChecked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samplesChecked++;
      if (seen !== exp) begin
         errors++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge core_clk);
      regReq <= '{addr: a, wrData: v, wr: 1'b1, rd: 1'b0};
      @(posedge core_clk);
      regReq.wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge core_clk);
      regReq <= '{addr: a, wrData: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge core_clk);
      regReq.rd <= 1'b0;
      #1;
      v = regRdData;
   endtask : rd

   task automatic pulseSleep;
      @(posedge core_clk);
      sleepExec <= 1'b1;
      @(posedge core_clk);
      sleepExec <= 1'b0;
      #1;
   endtask : pulseSleep

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset;
      rd(OFS_HALT, d);
      chk("halt", d, HALT_RESET);
      chk("run", moduleRun, 16'hC000);
   endtask : t_reset

   task automatic t_divider;
      logic [15:0] prevLen;
      int          en;
      prevLen = 16'h0001;
      for (int k = 0; k <= 5; k++) begin
         cycLen <= 4'h0;
         wr(OFS_CLK_CTRL, 16'(k));
         tick(3);
         chk("memLenHeld", {9'h000, memAccessLen}, prevLen);
         cycLen <= 4'h2;
         tick(4);
         chk("memLen", {9'h000, memAccessLen}, 16'h0001 << k);
         chk("ioLen", {9'h000, ioAccessLen}, 16'h0002 << k);
         en = 0;
         for (int c = 0; c < 32; c++) begin
            tick(1);
            en += int'(masterClkEn);
         end
         chk("clkEn", 16'(en), 16'(32 >> k));
         prevLen = 16'h0001 << k;
      end
      wr(OFS_CLK_CTRL, 16'h0006);
      rd(OFS_CLK_CTRL, d);
      chk("divRefused", d & 16'h0007, 16'h0005);
      wr(OFS_CLK_CTRL, 16'h0000);
      tick(4);
      chk("memLenFull", {9'h000, memAccessLen}, 16'h0001);
   endtask : t_divider

   task automatic t_halt;
      modAccessReq <= 16'hFFFF;
      wr(OFS_HALT, 16'h0000);
      tick(4);
      chk("run", moduleRun, 16'hFEE0);
      chk("grant", modAccessGrant, 16'hFEE0);
      cycLen <= 4'h0;
      wr(OFS_HALT, 16'h033F);
      tick(3);
      chk("runHeld", moduleRun, 16'hFEE0);
      cycLen <= 4'h2;
      tick(4);
      chk("run", moduleRun, 16'hFCC0);
      chk("grant", modAccessGrant, 16'hFCC0);
      chk("clear", moduleStateClear, 16'h0220);
      rd(OFS_HALT, d);
      chk("haltRead", d, 16'h033F);
      wr(OFS_HALT, 16'h0000);
      dmaActive <= 1'b1;
      wr(OFS_HALT, 16'h8000);
      dmaActive  <= 1'b0;
      xferActive <= 1'b1;
      wr(OFS_HALT, 16'h4000);
      xferActive <= 1'b0;
      rd(OFS_HALT, d);
      chk("haltBusy", d, 16'h0000);
   endtask : t_halt

   task automatic t_sleep;
      wr(OFS_CLK_CTRL, 16'h0002);
      wr(OFS_HW_STANDBY_PIN_CTRL, 16'h0000);
      tick(4);
      pulseSleep();
      chk("mode", 16'(powerMode), 16'h0001);
      chk("cpuHalt", 16'(cpuHalt), 16'h0001);
      chk("run", moduleRun, 16'hFEE0);
      wake <= '{irqPending: 1'b1, nonNmiMasked: 1'b1, default: 1'b0};
      tick(3);
      chk("modeMasked", 16'(powerMode), 16'h0001);
      @(posedge core_clk);
      wake.nmiPending <= 1'b1;
      #1;
      chk("wakeExc", 16'(wakeException), 16'h0001);
      @(posedge core_clk);
      wake <= '0;
      #1;
      chk("modeRun", 16'(powerMode), 16'h0000);
      rd(OFS_STATUS, d);
      chk("status", d, 16'h0008);
   endtask : t_sleep

   task automatic t_swstby;
      wr(OFS_HALT, 16'h0020);
      wr(OFS_HW_STANDBY_PIN_CTRL, 16'h0080);
      pulseSleep();
      chk("mode", 16'(powerMode), 16'h0002);
      @(posedge core_clk);
      wake.extIrq <= 1'b1;
      #1;
      chk("wakeExc", 16'(wakeException), 16'h0001);
      @(posedge core_clk);
      wake <= '0;
      wr(OFS_HW_STANDBY_PIN_CTRL, 16'h0000);
      rd(OFS_HALT, d);
      chk("haltKept", d, 16'h0020);
      rd(OFS_STATUS, d);
      chk("status", d, 16'h0008);
   endtask : t_swstby

   task automatic t_hwstby;
      pulseSleep();
      hwStandbyPinN <= 1'b0;
      tick(8);
      chk("mode", 16'(powerMode), 16'h0003);
      hwStandbyPinN <= 1'b1;
      tick(8);
      rd(OFS_HALT, d);
      chk("haltReload", d, HALT_RESET);
      chk("runReload", moduleRun, 16'hC000);
      rd(OFS_STATUS, d);
      chk("status", d, 16'h0000);
   endtask : t_hwstby

   task automatic t_wdt;
      wr(OFS_HALT, 16'h0000);
      wr(OFS_CLK_CTRL, 16'h0002);
      tick(4);
      @(posedge core_clk);
      wdtReset <= 1'b1;
      @(posedge core_clk);
      wdtReset <= 1'b0;
      tick(2);
      chk("memLen", {9'h000, memAccessLen}, 16'h0001);
      chk("runWdt", moduleRun, 16'hC000);
      rd(OFS_HALT, d);
      chk("halt", d, HALT_RESET);
   endtask : t_wdt

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      errors         = 0;
      samplesChecked = 0;
      rst_n          = 1'b0;
      regReq         = '0;
      wake           = '0;
      hwStandbyPinN  = 1'b1;
      wdtReset       = 1'b0;
      sleepExec      = 1'b0;
      dmaActive      = 1'b0;
      xferActive     = 1'b0;
      modAccessReq   = 16'h0000;
      cycLen         = 4'h2;
      repeat (12) @(posedge core_clk);
      rst_n <= 1'b1;
      t_reset();
      t_divider();
      t_halt();
      t_sleep();
      t_swstby();
      t_hwstby();
      t_wdt();
      summarize();
   end

   initial begin
      repeat (20000) @(posedge core_clk);
      errors++;
      summarize();
   end
endmodule : tb
`default_nettype wire
